// ===== mssp_pkg.sv
package mssp_pkg;
    // clock and check cadence
    localparam int CLK_HZ          = 50_000_000;                 // clk_sys rate
    localparam int CHECK_US        = 100;                        // fast protection check period
    localparam int CHECK_CYC       = CLK_HZ / 1_000_000 * CHECK_US;
    localparam int SLOW_MS         = 1;                          // slow protection check period
    localparam int SLOW_TICKS      = SLOW_MS * 1000 / CHECK_US;  // fast ticks per slow tick
    localparam int CHK_W           = 24;                         // width of the check prescaler
    // pwm command input
    localparam int PWM_MIN_HZ      = 10;                         // slowest legal command frequency
    localparam int PWM_TIMEOUT_CYC = CLK_HZ / PWM_MIN_HZ;        // no rising edge for this long: static
    localparam int PER_W           = 24;                         // period / high-time counters
    localparam int NUM_W           = PER_W + 12;                 // high time times full-scale rpm
    localparam int DIV_STEPS       = NUM_W;                      // serial divider iterations
    // timed sequence, in 1 ms ticks
    localparam int MS_W            = 14;
    localparam int SEQ_START_MS    = 3000;                       // delay after reset release
    localparam int SEQ_STEP_MS     = 10000;                      // each speed step and the first two holds
    localparam int SEQ_REARM_MS    = 1000;                       // last hold before counter clear
    // speeds in rpm
    localparam int RPM_W           = 13;                         // signed speed command width
    localparam int RPM_STEP1       = 1000;
    localparam int RPM_STEP2       = 2000;
    localparam int RPM_STEP3       = 3000;
    localparam int RPM_FULL        = 3000;                       // 100 % duty
    localparam int RPM_MIN         = 500;                        // lowest regulated speed
    localparam int RPM_OVERSPEED   = 5000;
    // measurement scaling and limits
    localparam int MEAS_W          = 16;                         // signed measurement width
    localparam int OC_LIM_10MA     = 1697;                       // 16.97 A in 10 mA units
    localparam int OV_LIM_100MV    = 280;                        // 28.0 V in 100 mV units
    localparam int UV_LIM_100MV    = 80;                         // 8.0 V in 100 mV units
    localparam int BOARD_LIM_C     = 120;
    localparam int COIL_LIM_C      = 180;
    // fault flag positions
    localparam int FLT_OC          = 0;
    localparam int FLT_OV          = 1;
    localparam int FLT_UV          = 2;
    localparam int FLT_OS          = 3;
    localparam int FLT_STOP        = 4;
    localparam int FLT_BOARD       = 5;
    localparam int FLT_COIL        = 6;
    localparam int FLT_N           = 7;
    localparam int GATE_N          = 6;
    // timed sequence states
    typedef enum logic [2:0] {
        SEQ_WAIT, SEQ_RUN1, SEQ_RUN2, SEQ_RUN3, SEQ_HOLD1, SEQ_HOLD2, SEQ_HOLD3
    } mssp_seq_t;
endpackage : mssp_pkg

// ===== mssp_pwm_src.sv
`timescale 1ns/10ps
// external speed command source; period scaled down with the block's timeout
module mssp_pwm_src (
    input wire logic        clk_sys,
    input wire logic [15:0] period,  // cycles per pwm period
    input wire logic [15:0] high,    // high cycles; >= period is a steady high
    output logic            pwm
);
    logic [15:0] cnt = 16'h0000; // position in period
    initial pwm = 1'b0;
    // changes only on the falling edge, like the rest of the stimulus
    always @(negedge clk_sys) begin
        cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
        pwm <= cnt < high;
    end
endmodule : mssp_pwm_src

// ===== mssp_top.sv
`timescale 1ns/10ps
// What this block does
// - one start mode, strapped: timed or pwm
// - timed: wait 3 s, then 1000 rpm
// - timed: 10 s later, 2000 rpm
// - timed: 10 s later, 3000 rpm
// - timed: 10 s later, stop rotation
// - timed: holds, last 1 s, then counter clear
// - pwm: 100 % duty gives 3000 rpm
// - pwm: 0 % duty gives 0 rpm
// - both directions, 500 to 3000 rpm
// - any fault turns off all six gates
// - overcurrent above 16.97 A, every 100 us
// - overvoltage above 28.0 V, every 100 us
// - undervoltage below 8.0 V, every 100 us
// - overspeed above 5000 rpm, every 1 ms
// - stop pin low kills gates without clock
// - board above 120 C, every 1 ms
// - coil above 180 C, every 1 ms
module mssp_top
    import mssp_pkg::*;
#(
    parameter int CHECK_CYCLES   = mssp_pkg::CHECK_CYC,       // shorten for simulation
    parameter int PWM_TIMEOUT    = mssp_pkg::PWM_TIMEOUT_CYC  // shorten for simulation
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rstn,
    input  wire logic                      mode_pwm_sel,        // strap: 1 = pwm command mode
    input  wire logic                      dir_ccw,             // pin: 1 = counter-clockwise
    input  wire logic                      pwm_cmd_in,          // pin: speed command pwm
    input  wire logic                      external_stop_input, // pin: low = emergency stop
    input  wire logic [GATE_N-1:0]         gate_demand,         // gate pattern from modulator
    input  wire logic signed [MEAS_W-1:0]  i_u,                 // phase currents, 10 mA units
    input  wire logic signed [MEAS_W-1:0]  i_v,
    input  wire logic signed [MEAS_W-1:0]  i_w,
    input  wire logic [MEAS_W-1:0]         vdc,                 // bus voltage, 100 mV units
    input  wire logic signed [MEAS_W-1:0]  speed_est,           // estimated speed, rpm
    input  wire logic signed [MEAS_W-1:0]  board_temp,          // degrees C
    input  wire logic signed [MEAS_W-1:0]  coil_temp,           // degrees C
    output logic [GATE_N-1:0]              gate_out,            // active high gate drives
    output logic signed [RPM_W-1:0]        speed_cmd,           // signed rpm command
    output logic                           motor_run,
    output logic [FLT_N-1:0]               fault_flags,
    output logic                           fault_any,
    output logic                           mode_is_pwm
);
    import mssp_pkg::*;

    // magnitude of a signed measurement
    function automatic logic [MEAS_W-1:0] mag(input logic signed [MEAS_W-1:0] x);
        mag = x[MEAS_W-1] ? MEAS_W'(-x) : MEAS_W'(x);
    endfunction : mag

    // how long each sequence state lasts, in ms ticks
    function automatic logic [MS_W-1:0] seq_dur(input mssp_seq_t s);
        case (s)
            SEQ_WAIT:  seq_dur = MS_W'(SEQ_START_MS);
            SEQ_HOLD3: seq_dur = MS_W'(SEQ_REARM_MS);
            default:   seq_dur = MS_W'(SEQ_STEP_MS);
        endcase
    endfunction : seq_dur

    // pin synchronisers; stage one is read only by stage two
    logic [3:0] pin_s1;                  // first stage
    logic [3:0] pin_s2;                  // {stop, pwm, dir, mode}
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            // stop bit resets to its idle high level, so no false stop follows reset
            pin_s1 <= 4'h8;
            pin_s2 <= 4'h8;
        end else begin
            pin_s1 <= {external_stop_input, pwm_cmd_in, dir_ccw, mode_pwm_sel};
            pin_s2 <= pin_s1;
        end
    end

    // check prescaler: fast tick every 100 us, slow tick every 1 ms
    logic [CHK_W-1:0] chk_cnt, next_chk_cnt;
    logic [3:0]       slow_cnt, next_slow_cnt;
    logic             chk_tick, next_chk_tick;   // one-cycle pulse
    logic             slow_tick, next_slow_tick; // one-cycle pulse, with a fast tick
    always_comb begin
        next_chk_cnt   = chk_cnt + CHK_W'(1);
        next_slow_cnt  = slow_cnt;
        next_chk_tick  = 1'b0;
        next_slow_tick = 1'b0;
        if (chk_cnt == CHK_W'(CHECK_CYCLES - 1)) begin
            next_chk_cnt  = '0;
            next_chk_tick = 1'b1;
            if (slow_cnt == 4'(SLOW_TICKS - 1)) begin
                next_slow_cnt  = 4'h0;
                next_slow_tick = 1'b1;
            end else begin
                next_slow_cnt = slow_cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chk_cnt   <= '0;
            slow_cnt  <= 4'h0;
            chk_tick  <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            chk_cnt   <= next_chk_cnt;
            slow_cnt  <= next_slow_cnt;
            chk_tick  <= next_chk_tick;
            slow_tick <= next_slow_tick;
        end
    end

    // mode strap caught at the first check tick, when the synchroniser has settled
    logic mode_done, next_mode_done;
    logic mode_pwm, next_mode_pwm;
    always_comb begin
        next_mode_done = mode_done;
        next_mode_pwm  = mode_pwm;
        if (!mode_done && chk_tick) begin
            next_mode_done = 1'b1;
            next_mode_pwm  = pin_s2[0];
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_done <= 1'b0;
            mode_pwm  <= 1'b0;
        end else begin
            mode_done <= next_mode_done;
            mode_pwm  <= next_mode_pwm;
        end
    end

    // timed sequence; runs only in timed mode, counts ms ticks
    mssp_seq_t       seq, next_seq;
    logic [MS_W-1:0] ms_cnt, next_ms_cnt;
    logic [RPM_W-1:0] seq_rpm;           // magnitude for the current state
    always_comb begin
        next_seq    = seq;
        next_ms_cnt = ms_cnt;
        if (mode_done && !mode_pwm && slow_tick) begin
            if (ms_cnt == seq_dur(seq) - MS_W'(1)) begin
                next_ms_cnt = '0;
                case (seq)
                    SEQ_WAIT:  next_seq = SEQ_RUN1;
                    SEQ_RUN1:  next_seq = SEQ_RUN2;
                    SEQ_RUN2:  next_seq = SEQ_RUN3;
                    SEQ_RUN3:  next_seq = SEQ_HOLD1;
                    SEQ_HOLD1: next_seq = SEQ_HOLD2;
                    SEQ_HOLD2: next_seq = SEQ_HOLD3;
                    default:   next_seq = SEQ_WAIT;
                endcase
            end else begin
                next_ms_cnt = ms_cnt + MS_W'(1);
            end
        end
        case (seq)
            SEQ_RUN1: seq_rpm = RPM_W'(RPM_STEP1);
            SEQ_RUN2: seq_rpm = RPM_W'(RPM_STEP2);
            SEQ_RUN3: seq_rpm = RPM_W'(RPM_STEP3);
            default:  seq_rpm = '0;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            seq    <= SEQ_WAIT;
            ms_cnt <= '0;
        end else begin
            seq    <= next_seq;
            ms_cnt <= next_ms_cnt;
        end
    end

    // pwm capture: period and high time between rising edges
    logic [PER_W-1:0] pw_cnt, next_pw_cnt;       // cycles since last rising edge
    logic [PER_W-1:0] pw_high, next_pw_high;     // high time of the running period
    logic [PER_W-1:0] per_lat, next_per_lat;     // divisor of the running division
    logic [NUM_W-1:0] num, next_num;             // dividend, shifted out msb first
    logic [PER_W:0]   rem, next_rem;             // division remainder
    logic [11:0]      quo, next_quo;             // quotient being built
    logic [5:0]       div_left, next_div_left;   // iterations still to run
    logic [11:0]      pwm_rpm, next_pwm_rpm;     // last settled command
    logic             pwm_prev, next_pwm_prev;
    logic [PER_W:0]   rem_sh;
    always_comb begin
        next_pw_cnt   = pw_cnt;
        next_pw_high  = pw_high;
        next_per_lat  = per_lat;
        next_num      = num;
        next_rem      = rem;
        next_quo      = quo;
        next_div_left = div_left;
        next_pwm_rpm  = pwm_rpm;
        next_pwm_prev = pin_s2[2];
        rem_sh        = {rem[PER_W-1:0], num[NUM_W-1]};
        if (pw_cnt != PER_W'(PWM_TIMEOUT))
            next_pw_cnt = pw_cnt + PER_W'(1);
        if (pwm_prev && !pin_s2[2])
            next_pw_high = pw_cnt;                           // falling edge ends high time
        if (!pwm_prev && pin_s2[2]) begin
            // a new period starts: divide high*full by period; a 1 kHz period is
            // far longer than the division, so a running one is never cut short
            next_pw_cnt   = PER_W'(1);
            next_per_lat  = pw_cnt;
            next_num      = NUM_W'(pw_high) * NUM_W'(RPM_FULL);
            next_rem      = '0;
            next_quo      = 12'h000;
            next_div_left = 6'(DIV_STEPS);
        end else if (div_left != 6'h00) begin
            next_num      = {num[NUM_W-2:0], 1'b0};
            next_div_left = div_left - 6'h01;
            if (rem_sh >= {1'b0, per_lat}) begin
                next_rem = rem_sh - {1'b0, per_lat};
                next_quo = {quo[10:0], 1'b1};
            end else begin
                next_rem = rem_sh;
                next_quo = {quo[10:0], 1'b0};
            end
            if (div_left == 6'h01)
                next_pwm_rpm = (next_quo > 12'(RPM_FULL)) ? 12'(RPM_FULL) : next_quo;
        end else if (pw_cnt == PER_W'(PWM_TIMEOUT)) begin
            // no rising edge for a whole slowest period: the line is static
            next_pwm_rpm = pin_s2[2] ? 12'(RPM_FULL) : 12'h000;
            next_pw_high = pin_s2[2] ? PER_W'(PWM_TIMEOUT) : '0;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pw_cnt   <= '0;
            pw_high  <= '0;
            per_lat  <= '0;
            num      <= '0;
            rem      <= '0;
            quo      <= 12'h000;
            div_left <= 6'h00;
            pwm_rpm  <= 12'h000;
            pwm_prev <= 1'b0;
        end else begin
            pw_cnt   <= next_pw_cnt;
            pw_high  <= next_pw_high;
            per_lat  <= next_per_lat;
            num      <= next_num;
            rem      <= next_rem;
            quo      <= next_quo;
            div_left <= next_div_left;
            pwm_rpm  <= next_pwm_rpm;
            pwm_prev <= next_pwm_prev;
        end
    end

    // protection checks and latched flags
    logic [FLT_N-1:0]  flt, next_flt;
    logic [GATE_N-1:0] gate_q, next_gate_q;
    logic signed [RPM_W-1:0] next_speed_cmd;
    logic              next_motor_run;
    logic              next_fault_any;   // summary, registered with the flags
    logic [FLT_N-1:0]  hit;              // conditions seen at this tick
    logic [RPM_W-1:0]  cmd_mag;          // unsigned command before direction
    always_comb begin
        hit = '0;
        if (chk_tick) begin
            hit[FLT_OC] = (mag(i_u) > MEAS_W'(OC_LIM_10MA)) ||
                          (mag(i_v) > MEAS_W'(OC_LIM_10MA)) ||
                          (mag(i_w) > MEAS_W'(OC_LIM_10MA));
            hit[FLT_OV]   = vdc > MEAS_W'(OV_LIM_100MV);
            hit[FLT_UV]   = vdc < MEAS_W'(UV_LIM_100MV);
            hit[FLT_STOP] = !pin_s2[3];
        end
        if (slow_tick) begin
            hit[FLT_OS]    = mag(speed_est) > MEAS_W'(RPM_OVERSPEED);
            hit[FLT_BOARD] = board_temp > $signed(MEAS_W'(BOARD_LIM_C));
            hit[FLT_COIL]  = coil_temp > $signed(MEAS_W'(COIL_LIM_C));
        end
        next_flt = flt | hit;
        // gates off as soon as any flag stands, for good
        next_gate_q = (|next_flt) ? '0 : gate_demand;
        // pick the strapped source; nothing runs before the strap is caught
        if (!mode_done)
            cmd_mag = '0;
        else if (mode_pwm)
            cmd_mag = RPM_W'(pwm_rpm);
        else
            cmd_mag = seq_rpm;
        // below the regulated range the motor is held stopped instead
        if (cmd_mag < RPM_W'(RPM_MIN) || (|next_flt))
            cmd_mag = '0;
        next_speed_cmd = pin_s2[1] ? -$signed(cmd_mag) : $signed(cmd_mag);
        next_motor_run = cmd_mag != '0;
        next_fault_any = |next_flt;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flt       <= '0;
            gate_q    <= '0;
            speed_cmd <= '0;
            motor_run <= 1'b0;
            fault_any <= 1'b0;
        end else begin
            flt       <= next_flt;
            gate_q    <= next_gate_q;
            speed_cmd <= next_speed_cmd;
            motor_run <= next_motor_run;
            fault_any <= next_fault_any;
        end
    end

    // the stop pin gates gate_out without a clock edge; this is the one
    // path that bypasses the flops, traded for zero latency on an emergency stop
    assign gate_out    = gate_q & {GATE_N{external_stop_input}};
    assign fault_flags = flt;
    assign mode_is_pwm = mode_pwm;
endmodule : mssp_top

// ===== mssp_top_asserts.sv
`timescale 1ns/10ps
// watches the block's pins only; bound into every instance
module mssp_checker
    import mssp_pkg::*;
#(
    parameter int CHECK_CYCLES = mssp_pkg::CHECK_CYC // must match the bound block
) (
    input wire logic                     clk_sys,
    input wire logic                     rstn,
    input wire logic                     mode_pwm_sel,
    input wire logic                     dir_ccw,
    input wire logic                     pwm_cmd_in,
    input wire logic                     external_stop_input,
    input wire logic [GATE_N-1:0]        gate_demand,
    input wire logic signed [MEAS_W-1:0] i_u,
    input wire logic signed [MEAS_W-1:0] i_v,
    input wire logic signed [MEAS_W-1:0] i_w,
    input wire logic [MEAS_W-1:0]        vdc,
    input wire logic signed [MEAS_W-1:0] speed_est,
    input wire logic signed [MEAS_W-1:0] board_temp,
    input wire logic signed [MEAS_W-1:0] coil_temp,
    input wire logic [GATE_N-1:0]        gate_out,
    input wire logic signed [RPM_W-1:0]  speed_cmd,
    input wire logic                     motor_run,
    input wire logic [FLT_N-1:0]         fault_flags,
    input wire logic                     fault_any,
    input wire logic                     mode_is_pwm
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // phase current outside the band in either direction
    function automatic logic over_i(input logic signed [MEAS_W-1:0] x);
        return x > OC_LIM_10MA || x < -OC_LIM_10MA;
    endfunction : over_i
    logic        fast_bad;     // some condition of the 100 us group stands
    int unsigned bad_run;      // cycles it has stood without a break
    int unsigned next_bad_run;
    assign fast_bad = over_i(i_u) || over_i(i_v) || over_i(i_w) || vdc > OV_LIM_100MV
                      || vdc < UV_LIM_100MV || !external_stop_input;
    // count next value; a gap restarts, since conditions between ticks may be missed
    always_comb begin
        next_bad_run = fast_bad ? bad_run + 1 : 0;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bad_run <= 0;
        end else begin
            bad_run <= next_bad_run;
        end
    end
    // a full check period plus sync slack must have caught it
    property p_fast_seen;
        bad_run > CHECK_CYCLES + 4 |-> (fault_flags & 7'h17) != 7'h00;
    endproperty
    a_fast_seen: assert property (p_fast_seen) else $error("fast fault not flagged");
    property p_stop_gate;
        !external_stop_input |-> gate_out == 6'h00;
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("gates on with stop low");
    property p_fault_gate;
        fault_any |-> gate_out == 6'h00 && speed_cmd == 0 && !motor_run;
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("drive on after fault");
    property p_sticky;
        ($past(fault_flags) & ~fault_flags) == 7'h00;
    endproperty
    a_sticky: assert property (p_sticky) else $error("fault bit cleared");
    property p_any;
        fault_any == (fault_flags != 7'h00);
    endproperty
    a_any: assert property (p_any) else $error("fault summary wrong");
    property p_run;
        motor_run == (speed_cmd != 0);
    endproperty
    a_run: assert property (p_run) else $error("run flag disagrees");
    property p_range;
        speed_cmd == 0 || (speed_cmd >= RPM_MIN && speed_cmd <= RPM_FULL)
        || (speed_cmd <= -RPM_MIN && speed_cmd >= -RPM_FULL);
    endproperty
    a_range: assert property (p_range) else $error("command out of range");
    property p_mode;
        !$fell(mode_is_pwm) && (!$rose(mode_is_pwm) || mode_pwm_sel);
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed");
    c_step1: cover property (speed_cmd == RPM_STEP1);
    c_fault: cover property ($rose(fault_any));
    c_pwm:   cover property (mode_is_pwm && speed_cmd == RPM_FULL);
endmodule : mssp_checker
bind mssp_top mssp_checker #(.CHECK_CYCLES(CHECK_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .mode_pwm_sel(mode_pwm_sel), .dir_ccw(dir_ccw),
    .pwm_cmd_in(pwm_cmd_in), .external_stop_input(external_stop_input),
    .gate_demand(gate_demand), .i_u(i_u), .i_v(i_v), .i_w(i_w), .vdc(vdc),
    .speed_est(speed_est), .board_temp(board_temp), .coil_temp(coil_temp),
    .gate_out(gate_out), .speed_cmd(speed_cmd), .motor_run(motor_run),
    .fault_flags(fault_flags), .fault_any(fault_any), .mode_is_pwm(mode_is_pwm));

// ===== test_mssp_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_mssp_top;
    import mssp_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, mode_pwm_sel = 1'b0, dir_ccw = 1'b0, pwm_cmd_in;
    logic external_stop_input = 1'b1;
    logic [GATE_N-1:0] gate_demand = 6'h25, gate_out;
    logic signed [MEAS_W-1:0] i_u, i_v, i_w, speed_est, board_temp, coil_temp;
    logic [MEAS_W-1:0] vdc;
    logic signed [RPM_W-1:0] speed_cmd;
    logic motor_run, fault_any, mode_is_pwm;
    logic [FLT_N-1:0] fault_flags;
    logic [15:0] period = 16'h0190, high = 16'h0000; // 400-cycle command period
    int miscompares = 0, checks_done = 0;
    always #10 clk_sys = ~clk_sys;
    mssp_top #(.CHECK_CYCLES(2), .PWM_TIMEOUT(4000)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .mode_pwm_sel(mode_pwm_sel), .dir_ccw(dir_ccw),
        .pwm_cmd_in(pwm_cmd_in), .external_stop_input(external_stop_input),
        .gate_demand(gate_demand), .i_u(i_u), .i_v(i_v), .i_w(i_w), .vdc(vdc),
        .speed_est(speed_est), .board_temp(board_temp), .coil_temp(coil_temp),
        .gate_out(gate_out), .speed_cmd(speed_cmd), .motor_run(motor_run),
        .fault_flags(fault_flags), .fault_any(fault_any), .mode_is_pwm(mode_is_pwm));
    mssp_pwm_src u_src (.clk_sys(clk_sys), .period(period), .high(high), .pwm(pwm_cmd_in));
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_n
    // healthy measurements, all well inside the limits
    task automatic set_nominal;
        i_u = 16'sh0000; i_v = 16'sh0064; i_w = -16'sh0064; vdc = 16'h00f0;
        speed_est = 16'sh0000; board_temp = 16'sh0019; coil_temp = 16'sh0019;
        external_stop_input = 1'b1;
    endtask : set_nominal
    // two cycles low, mode strap settled before release
    task automatic do_reset(input logic pwm_mode);
        @(negedge clk_sys);
        rstn = 1'b0; mode_pwm_sel = pwm_mode; set_nominal();
        wait_n(2);
        rstn = 1'b1;
    endtask : do_reset
    // 3000 ms of 1 ms ticks (20 cycles each here) before the first step
    task automatic run_timed;
        do_reset(1'b0);
        wait_n(59000);
        `CHK(speed_cmd, RPM_W'(0))
        wait_n(2000);
        `CHK({motor_run, mode_is_pwm}, 2'b10)
        `CHK(speed_cmd, RPM_W'(RPM_STEP1))
        `CHK(gate_out, gate_demand)
        external_stop_input = 1'b0;
        #1 `CHK(gate_out, 6'h00)
        wait_n(10);
        `CHK(fault_flags, 7'h10)
    endtask : run_timed
    // exact limit values are still healthy
    task automatic run_limits;
        do_reset(1'b1);
        i_u = 16'sd1697; i_v = -16'sd1697; vdc = 16'd280; speed_est = 16'sd5000;
        board_temp = 16'sd120; coil_temp = 16'sd180;
        wait_n(40);
        vdc = 16'd80;
        wait_n(40);
        `CHK(fault_flags, 7'h00)
    endtask : run_limits
    // each fault alone, one past its limit; then it must stay latched
    task automatic run_faults;
        int b;
        for (int k = 0; k < 8; k++) begin
            do_reset(1'b1);
            case (k)
                0: begin i_u = 16'sd1698; b = FLT_OC; end
                1: begin i_w = -16'sd1698; b = FLT_OC; end
                2: begin vdc = 16'd281; b = FLT_OV; end
                3: begin vdc = 16'd79; b = FLT_UV; end
                4: begin speed_est = 16'sd5001; b = FLT_OS; end
                5: begin board_temp = 16'sd121; b = FLT_BOARD; end
                6: begin coil_temp = 16'sd181; b = FLT_COIL; end
                default: begin external_stop_input = 1'b0; b = FLT_STOP; end
            endcase
            wait_n(40);
            `CHK(fault_flags, 7'h01 << b)
            `CHK({fault_any, gate_out}, 7'h40)
            set_nominal();
            wait_n(40);
            `CHK(fault_flags, 7'h01 << b)
        end
    endtask : run_faults
    // duty to rpm, direction and the steady-level cases
    task automatic run_pwm;
        int hi [5] = '{200, 300, 40, 400, 0};
        int ex [5] = '{1500, 2250, 0, 3000, 0};
        do_reset(1'b1);
        for (int k = 0; k < 5; k++) begin
            high = 16'(hi[k]);
            wait_n(k < 3 ? 1400 : 5000);
            `CHK(speed_cmd, RPM_W'(ex[k]))
        end
        high = 16'h00c8; dir_ccw = 1'b1;
        wait_n(1400);
        `CHK(speed_cmd, RPM_W'(-1500))
        `CHK(mode_is_pwm, 1'b1)
        dir_ccw = 1'b0;
        high = 16'h0000;
        wait_n(5000);
        `CHK({motor_run, speed_cmd}, 14'h0000)
    endtask : run_pwm
    task automatic finish_test;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        set_nominal();
        run_limits();
        run_faults();
        run_pwm();
        run_timed();
        finish_test();
    end
    // about 82k cycles expected; give up at 95k so a hang stays short
    initial begin
        #1900000;
        miscompares++;
        finish_test();
    end
endmodule : test_mssp_top
